// >>> src/oiop_defs.vh
// Purpose: constants for the octal I/O port with analog and wakeup roles
// Assumes: classic Wishbone, 32-bit data, register index times four
// Notes: printed offsets are register indices
`ifndef OIOP_DEFS_VH
`define OIOP_DEFS_VH

`define OIOP_IDX_OUTPUT_LATCH 12'h004
`define OIOP_IDX_PIN_READBACK 12'h011
`define OIOP_IDX_DIRECTION 12'hF1E
`define OIOP_IDX_PULLUP 12'hF2B
`define OIOP_IDX_FUNC_SEL 12'hF38
`define OIOP_ADDR_W 14
`define OIOP_IDX_LSB 2
`define OIOP_WIDTH 8
`define OIOP_RESET_VAL 8'h00
`define OIOP_RESET_BIT 1'b0
`define OIOP_ZERO_PAD 24'h000000
`define OIOP_ZERO_BYTE 8'h00

`endif

// >>> src/oiop_port.v
// Purpose: eight-bit I/O port with analog input and key-on wakeup roles
// Assumes: classic Wishbone slave, byte address = register index * 4
// Notes: ack comes one cycle after the request is seen, drops next cycle
// Behaviour
// - Eight port bits, each set as input or output on its own.
// - Each bit may also act as an analog input or a key-on wakeup input.
// - An output bit drives low for latch 0 and high for latch 1.
// - An enabled wakeup input sees the pin whatever the direction bit.
// - An enabled wakeup input works whatever the function-select bit.
// - Pull-up connects only if its bit is 1 and wakeup or plain input.
// - Input-data read gives the pin for a plain input bit and 0 otherwise.
`timescale 1ns/1ps
`include "oiop_defs.vh"

module oiop_port (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [3:0] sel_i,
	input wire [`OIOP_ADDR_W-1:0] adr_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	input wire [7:0] pin_i,
	output reg [7:0] pin_o,
	output reg [7:0] pin_oe_o,
	output reg [7:0] pullup_en_o,
	output reg [7:0] analog_channel_in_o,
	output reg [7:0] analog_sel_o,
	input wire [7:0] wakeup_enable_bit_i,
	output reg [7:0] key_wakeup_in_o
);

	reg [7:0] port_output_latch;
	reg [7:0] port_direction_control;
	reg [7:0] port_pullup_control;
	reg [7:0] port_function_select;
	wire [11:0] idx;
	wire req;
	wire wr;
	wire hit_latch;
	wire hit_readback;
	wire hit_direction;
	wire hit_pullup;
	wire hit_func_sel;
	wire wr_latch;
	wire wr_direction;
	wire wr_pullup;
	wire wr_func_sel;
	wire [7:0] plain_in;
	wire [7:0] pullup_allowed;
	wire [7:0] next_pin;
	wire [7:0] next_oe;
	wire [7:0] next_pullup;
	wire [7:0] next_analog;
	wire [7:0] next_asel;
	wire [7:0] next_wake;
	reg [7:0] next_rdata;
	reg next_ack;
	reg [31:0] next_dat;

	// register index sits above the byte lanes
	assign idx = adr_i[`OIOP_ADDR_W-1:`OIOP_IDX_LSB];
	// ack high blocks a held strobe being taken twice in a row
	assign req = cyc_i & stb_i & ~ack_o;
	// only byte lane 0 carries register data
	assign wr = req & we_i & sel_i[0];
	assign hit_latch = (idx == `OIOP_IDX_OUTPUT_LATCH);
	assign hit_readback = (idx == `OIOP_IDX_PIN_READBACK);
	assign hit_direction = (idx == `OIOP_IDX_DIRECTION);
	assign hit_pullup = (idx == `OIOP_IDX_PULLUP);
	assign hit_func_sel = (idx == `OIOP_IDX_FUNC_SEL);
	// readback has no write strobe: writes there are dropped
	assign wr_latch = wr & hit_latch;
	assign wr_direction = wr & hit_direction;
	assign wr_pullup = wr & hit_pullup;
	assign wr_func_sel = wr & hit_func_sel;

	// plain input: direction 0 and function-select 0
	assign plain_in = ~port_direction_control & ~port_function_select;
	assign pullup_allowed = wakeup_enable_bit_i | plain_in;

	// unmapped indices read as zero
	always @* begin
		next_rdata = `OIOP_ZERO_BYTE;
		if (hit_latch)
			next_rdata = port_output_latch;
		if (hit_readback)
			next_rdata = pin_i & plain_in;
		if (hit_direction)
			next_rdata = port_direction_control;
		if (hit_pullup)
			next_rdata = port_pullup_control;
		if (hit_func_sel)
			next_rdata = port_function_select;
	end

	// read data stands until the next taken request
	always @* begin
		next_ack = req;
		next_dat = dat_o;
		if (req)
			next_dat = {`OIOP_ZERO_PAD, next_rdata};
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= `OIOP_RESET_BIT;
			dat_o <= {`OIOP_ZERO_PAD, `OIOP_RESET_VAL};
		end else if (ce_i) begin
			ack_o <= next_ack;
			dat_o <= next_dat;
		end
	end

	// level driven on output-mode bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			port_output_latch <= `OIOP_RESET_VAL;
		end else if (ce_i && wr_latch) begin
			port_output_latch <= dat_i[`OIOP_WIDTH-1:0];
		end
	end

	// one direction bit per pin, each set on its own
	always @(posedge clk_i) begin
		if (rst_i) begin
			port_direction_control <= `OIOP_RESET_VAL;
		end else if (ce_i && wr_direction) begin
			port_direction_control <= dat_i[`OIOP_WIDTH-1:0];
		end
	end

	// pull-up request, gated by the bit's mode below
	always @(posedge clk_i) begin
		if (rst_i) begin
			port_pullup_control <= `OIOP_RESET_VAL;
		end else if (ce_i && wr_pullup) begin
			port_pullup_control <= dat_i[`OIOP_WIDTH-1:0];
		end
	end

	// analog role select per bit
	always @(posedge clk_i) begin
		if (rst_i) begin
			port_function_select <= `OIOP_RESET_VAL;
		end else if (ce_i && wr_func_sel) begin
			port_function_select <= dat_i[`OIOP_WIDTH-1:0];
		end
	end

	assign next_pin = port_output_latch;
	// analog role takes the pin off the port driver
	assign next_oe = port_direction_control &
		~port_function_select;
	assign next_pullup = port_pullup_control & pullup_allowed;
	assign next_asel = port_function_select;
	assign next_analog = pin_i & port_function_select;
	// wakeup path ignores direction and function select
	assign next_wake = pin_i & wakeup_enable_bit_i;

	// pin side: every output is a flip-flop
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_o <= `OIOP_RESET_VAL;
		end else if (ce_i) begin
			pin_o <= next_pin;
		end
	end

	// driver on only in port output mode
	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_oe_o <= `OIOP_RESET_VAL;
		end else if (ce_i) begin
			pin_oe_o <= next_oe;
		end
	end

	// pull-up only on plain-input or wakeup-enabled bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			pullup_en_o <= `OIOP_RESET_VAL;
		end else if (ce_i) begin
			pullup_en_o <= next_pullup;
		end
	end

	// analog switch select
	always @(posedge clk_i) begin
		if (rst_i) begin
			analog_sel_o <= `OIOP_RESET_VAL;
		end else if (ce_i) begin
			analog_sel_o <= next_asel;
		end
	end

	// analog copy follows the live pin
	always @(posedge clk_i) begin
		if (rst_i) begin
			analog_channel_in_o <= `OIOP_RESET_VAL;
		end else if (ce_i) begin
			analog_channel_in_o <= next_analog;
		end
	end

	// wakeup copy, frozen with the rest while ce_i is low
	always @(posedge clk_i) begin
		if (rst_i) begin
			key_wakeup_in_o <= `OIOP_RESET_VAL;
		end else if (ce_i) begin
			key_wakeup_in_o <= next_wake;
		end
	end

endmodule // oiop_port

// >>> verif/oiop_pins.sv
// Purpose: pin side model
// Assumes: pull-up beats an idle external driver
// Notes: ext_i drives pins nobody else drives
`timescale 1ns/1ps
module oiop_pins(input wire [7:0] oe_i,lvl_i,pu_i,ext_i,
	output wire [7:0] pin_o);
	assign pin_o = oe_i & lvl_i | ~oe_i & (pu_i | ext_i);
endmodule // oiop_pins

// >>> verif/oiop_port_sva.sv
// Purpose: port checks
// Assumes: ce_i high while ack is awaited
// Notes: watches top ports only
`timescale 1ns/1ps
module oiop_port_sva(input wire clk_i,rst_i,ce_i,cyc_i,stb_i,we_i,ack_o,
	input wire [13:0] adr_i,
	input wire [31:0] dat_o,
	input wire [7:0] pin_i,pin_oe_o,pullup_en_o,analog_channel_in_o,
	analog_sel_o,wakeup_enable_bit_i,key_wakeup_in_o);
default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);
wire run = ce_i & ~rst_i;
// readback request taken at this edge
wire rdb_take = run & cyc_i & stb_i & ~ack_o & ~we_i & (adr_i == 14'h0044);
AST_WAKE: assert property ($past(run) |->
	key_wakeup_in_o == $past(pin_i & wakeup_enable_bit_i)) else $error("wake");
AST_ADC: assert property ($past(run) |->
	analog_channel_in_o == ($past(pin_i) & analog_sel_o)) else $error("adc");
AST_OE: assert property ((pin_oe_o & analog_sel_o) == 8'h00)
	else $error("oe");
AST_PU: assert property ($past(run) |-> (pullup_en_o &
	~$past(wakeup_enable_bit_i) & (pin_oe_o | analog_sel_o)) == 8'h00)
	else $error("pu");
AST_ACK: assert property (run && cyc_i && stb_i && !ack_o |=> ack_o)
	else $error("ack");
AST_PULSE: assert property (ack_o && ce_i |=> !ack_o)
	else $error("pulse");
AST_PAD: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
	else $error("pad");
AST_RDB: assert property (ack_o && $past(rdb_take) |->
	dat_o[7:0] == $past(pin_i & ~(pin_oe_o | analog_sel_o)))
	else $error("rdb");
endmodule // oiop_port_sva

// >>> verif/test_oiop_port.sv
// Purpose: random register and pin tests
// Assumes: ce_i high whenever the bus is used
// Notes: seed 56
`timescale 1ns/1ps
module test_oiop_port;
reg clk_i=0,rst_i=1,cyc_i=0,stb_i=0,we_i=0;
reg [13:0] adr_i=0;
reg [31:0] dat_i=0;
reg [7:0] ext=0,wakeup_enable_bit_i=0,r,p,q,v[5];
reg ce_i=1;
reg [3:0] sel_i=4'hF,wsel=4'hF;
wire [31:0] dat_o;
wire ack_o;
wire [7:0] pin_i,pin_o,pin_oe_o,pullup_en_o,analog_channel_in_o,analog_sel_o,
	key_wakeup_in_o;
integer seed=56,error_cnt=0,samples_checked=0,n=0,i,j;
reg [13:0] a[5]='{14'h0010,14'h3C78,14'h3CAC,14'h3CE0,14'h0100};
oiop_port oiop_port_inst(.clk_i(clk_i),.rst_i(rst_i),.ce_i(ce_i),
	.cyc_i(cyc_i),.stb_i(stb_i),.we_i(we_i),.sel_i(sel_i),.adr_i(adr_i),
	.dat_i(dat_i),.dat_o(dat_o),.ack_o(ack_o),.pin_i(pin_i),.pin_o(pin_o),
	.pin_oe_o(pin_oe_o),.pullup_en_o(pullup_en_o),
	.analog_channel_in_o(analog_channel_in_o),.analog_sel_o(analog_sel_o),
	.wakeup_enable_bit_i(wakeup_enable_bit_i),
	.key_wakeup_in_o(key_wakeup_in_o));
oiop_pins oiop_pins_inst(.oe_i(pin_oe_o),.lvl_i(pin_o),.pu_i(pullup_en_o),
	.ext_i(ext),.pin_o(pin_i));
initial forever #2 clk_i=~clk_i;
always @(posedge clk_i) if (++n>3000) begin error_cnt++; wrap_up; end
task wrap_up;
	$display("checked %0d mismatches %0d",samples_checked,error_cnt);
	if (error_cnt==0 && samples_checked>0) $display("ALL TESTS PASSED");
	else $display("TESTS FAILED");
	$finish;
endtask
task chk(input string s,input [7:0] e,g);
	samples_checked++;
	if (e!==g) begin
		error_cnt++;
		$display("mismatch %s exp %h got %h",s,e,g);
	end
endtask
task wb(input w,input [13:0] ad,input [7:0] d);
	@(posedge clk_i)
		{cyc_i,stb_i,we_i,sel_i,adr_i,dat_i}<={2'h3,w,wsel,ad,24'h000000,d};
	@(posedge clk_i) while (!ack_o) @(posedge clk_i);
	r=dat_o[7:0];
	{cyc_i,stb_i}<=2'h0;
endtask
function [7:0] px(input [7:0] o,l,u);
	px=o&l|~o&(u|ext);
endfunction
initial begin
	repeat(5) @(posedge clk_i);
	rst_i<=0;
	for (j=0;j<5;j++) begin
		wb(0,a[j],0);
		chk("rst",8'h00,r);
	end
	for (i=0;i<20;i++) begin
		for (j=0;j<5;j++) begin
			v[j]=i<2?{8{i[0]}}:$random(seed);
			wb(1,a[j],v[j]);
		end
		ext<=$random(seed);
		wakeup_enable_bit_i<=$random(seed);
		repeat(3) @(posedge clk_i);
		for (j=0;j<5;j++) begin
			wb(0,a[j],0);
			chk("reg",j<4?v[j]:8'h00,r);
		end
		p=v[2]&(wakeup_enable_bit_i|~v[1]&~v[3]);
		chk("pu",p,pullup_en_o);
		chk("oe",v[1]&~v[3],pin_oe_o);
		chk("out",v[0],pin_o);
		chk("asel",v[3],analog_sel_o);
		p=px(v[1]&~v[3],v[0],p);
		q=wakeup_enable_bit_i&p;
		chk("wake",q,key_wakeup_in_o);
		chk("adc",v[3]&p,analog_channel_in_o);
		wb(0,14'h0044,0);
		chk("pins",~v[1]&~v[3]&p,r);
		$display("test %0d done",i);
	end
	// write with byte lane 0 off must not land
	wsel=4'hE;
	wb(1,a[0],~v[0]);
	wsel=4'hF;
	wb(0,a[0],0);
	chk("sel",v[0],r);
	chk("hold",v[0],pin_o);
	// clock enable low freezes the wakeup copy
	{ce_i,ext,wakeup_enable_bit_i}<={1'b0,~ext,8'hFF};
	repeat(3) @(posedge clk_i);
	chk("frz",q,key_wakeup_in_o);
	ce_i<=1;
	repeat(3) @(posedge clk_i);
	chk("pu_all",v[2],pullup_en_o);
	p=px(v[1]&~v[3],v[0],v[2]);
	chk("wk_all",p,key_wakeup_in_o);
	$display("test %0d done",i);
	wrap_up;
end
endmodule // test_oiop_port
bind oiop_port oiop_port_sva oiop_port_sva_inst(.clk_i(clk_i),.rst_i(rst_i),
	.ce_i(ce_i),.cyc_i(cyc_i),.stb_i(stb_i),.we_i(we_i),.ack_o(ack_o),
	.adr_i(adr_i),.dat_o(dat_o),.pin_i(pin_i),.pin_oe_o(pin_oe_o),
	.pullup_en_o(pullup_en_o),.analog_channel_in_o(analog_channel_in_o),
	.analog_sel_o(analog_sel_o),.wakeup_enable_bit_i(wakeup_enable_bit_i),
	.key_wakeup_in_o(key_wakeup_in_o));
